// ==== pwm_timer_pkg.sv ====
// constants, types and register map of the timer pwm output mode block
package pwm_timer_pkg;

  localparam int ADDR_W = 8;
  localparam int REG_COUNT = 13;

  // register word indices; byte address is four times the index
  localparam logic [3:0] IDX_CTL0 = 4'h0;   // timer_control_0
  localparam logic [3:0] IDX_CTL1 = 4'h1;   // timer_control_1
  localparam logic [3:0] IDX_CTL2 = 4'h2;   // timer_control_2
  localparam logic [3:0] IDX_IOC0 = 4'h3;   // output_pin_control
  localparam logic [3:0] IDX_IOC1 = 4'h4;   // input_pin_control_1
  localparam logic [3:0] IDX_IOC2 = 4'h5;   // trigger_edge_control
  localparam logic [3:0] IDX_CTL3 = 4'h6;   // input_pin_control_3
  localparam logic [3:0] IDX_OPT0 = 4'h7;   // option_reg_0
  localparam logic [3:0] IDX_OPT1 = 4'h8;   // option_reg_1
  localparam logic [3:0] IDX_PERIOD = 4'h9; // period_compare_reg
  localparam logic [3:0] IDX_DUTY = 4'hA;   // duty_compare_reg
  localparam logic [3:0] IDX_COUNT = 4'hB;  // counter_read_reg, read only
  localparam logic [3:0] IDX_TCW = 4'hC;    // counter_write_reg

  // writable bits per register
  localparam logic [15:0] MASK_CTL0 = 16'h0087;
  localparam logic [15:0] MASK_BYTE = 16'h00FF;
  localparam logic [15:0] MASK_IOC0 = 16'h000F;
  localparam logic [15:0] MASK_WORD = 16'hFFFF;
  localparam logic [15:0] MASK_NONE = 16'h0000;

  // field positions
  localparam int CTL0_CE = 7;      // count_enable_bit
  localparam int CTL0_CKS_LO = 0;  // count_clock_select, 3 bits
  localparam int CTL1_MD_LO = 0;   // operating_mode_select, 4 bits
  localparam int IOC0_OE0 = 0;
  localparam int IOC0_OL0 = 1;
  localparam int IOC0_OE1 = 2;     // pwm_out_enable
  localparam int IOC0_OL1 = 3;     // pwm_out_level

  localparam logic [3:0] MODE_PWM = 4'h4;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] CNT_IDLE = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_s;

endpackage

// ==== timer_unit.sv ====
// timer unit in pwm output mode with an axi4-lite register slave
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module timer_unit (
  input wire logic clk,                        // 50 MHz clock
  input wire logic srst,                       // synchronous reset, high
  input wire pwm_timer_pkg::axil_req_s bus_req, // axi4-lite master signals
  output pwm_timer_pkg::axil_rsp_s bus_rsp,    // axi4-lite slave signals
  output logic pwm_out_pin,                    // pwm waveform
  output logic pwm_out_oe,                     // pwm pin output enable
  output logic square_wave_out_pin,            // square wave
  output logic square_wave_out_oe,             // square pin output enable
  output logic period_match_irq,               // one-cycle pulse
  output logic duty_match_irq                  // one-cycle pulse
);
  import pwm_timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] reg_mask(input logic [3:0] idx);
    case (idx)
      IDX_CTL0: reg_mask = MASK_CTL0;
      IDX_IOC0: reg_mask = MASK_IOC0;
      IDX_PERIOD, IDX_DUTY, IDX_TCW: reg_mask = MASK_WORD;
      IDX_COUNT: reg_mask = MASK_NONE;
      default: reg_mask = MASK_BYTE;
    endcase
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] < 6'(REG_COUNT));
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [15:0] m);
    logic [15:0] bm;
    bm = {{8{st[1]}}, {8{st[0]}}} & m;
    merge = (old & ~bm) | (wd[15:0] & bm);
  endfunction

  // 2^cks - 1: the prescaler fires when all low bits are set
  function automatic logic [6:0] presc_mask(input logic [2:0] cks);
    presc_mask = 7'((8'h01 << cks) - 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register storage and bus write side
  logic [15:0] regs_q [0:REG_COUNT-1];
  logic aw_full_q, w_full_q, bvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic [3:0] wr_idx;
  logic duty_wr;

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_idx = awaddr_q[5:2];
  assign duty_wr = wr_fire && mapped(awaddr_q) && (wr_idx == IDX_DUTY);

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (bus_req.awvalid && !aw_full_q && !bvalid_q) begin
      aw_full_q <= 1'b1;
      awaddr_q <= bus_req.awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (bus_req.wvalid && !w_full_q && !bvalid_q) begin
      w_full_q <= 1'b1;
      wdata_q <= bus_req.wdata;
      wstrb_q <= bus_req.wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bus_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // the unused mode registers are stored for readback but steer nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (wr_fire && mapped(awaddr_q)) begin
      regs_q[wr_idx] <= merge(regs_q[wr_idx], wdata_q, wstrb_q, reg_mask(wr_idx));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register fields
  logic count_enable_bit;
  logic [2:0] count_clock_select;
  logic [3:0] operating_mode_select;
  logic pwm_out_enable, pwm_out_level, sq_enable, sq_level;
  logic running;

  assign count_enable_bit = regs_q[IDX_CTL0][CTL0_CE];
  assign count_clock_select = regs_q[IDX_CTL0][CTL0_CKS_LO +: 3];
  assign operating_mode_select = regs_q[IDX_CTL1][CTL1_MD_LO +: 4];
  assign pwm_out_enable = regs_q[IDX_IOC0][IOC0_OE1];
  assign pwm_out_level = regs_q[IDX_IOC0][IOC0_OL1];
  assign sq_enable = regs_q[IDX_IOC0][IOC0_OE0];
  assign sq_level = regs_q[IDX_IOC0][IOC0_OL0];
  assign running = count_enable_bit && (operating_mode_select == MODE_PWM);

  ////////////////////////////////////////////////////////////////////////
  // count clock prescaler
  logic [6:0] presc_q;
  logic tick;

  assign tick = running && ((presc_q & presc_mask(count_clock_select))
                            == presc_mask(count_clock_select));

  always_ff @(posedge clk) begin
    if (srst || !running) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter, shadow buffers and transfer arming
  logic [15:0] cnt_q, cnt_d, pbuf_q, dbuf_q, pbuf_nx, dbuf_nx;
  logic armed_q;
  logic clear_ev, zero_ev, duty_hit;

  assign clear_ev = tick && (cnt_q == pbuf_q);
  assign zero_ev = tick && ((cnt_q == pbuf_q) || (cnt_q == CNT_IDLE));
  assign pbuf_nx = (!running || (clear_ev && armed_q)) ? regs_q[IDX_PERIOD] : pbuf_q;
  assign dbuf_nx = (!running || (clear_ev && armed_q)) ? regs_q[IDX_DUTY] : dbuf_q;
  assign duty_hit = tick && (cnt_d == dbuf_nx);

  always_comb begin
    if (!running) begin
      cnt_d = CNT_IDLE;
    end else if (zero_ev) begin
      cnt_d = CNT_ZERO;
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= CNT_IDLE;
      pbuf_q <= REG_RESET;
      dbuf_q <= REG_RESET;
    end else begin
      cnt_q <= cnt_d;
      pbuf_q <= pbuf_nx;
      dbuf_q <= dbuf_nx;
    end
  end

  // a duty write in the clearing cycle keeps the arm for the next clear
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else if (duty_wr) begin
      armed_q <= 1'b1;
    end else if (!running || clear_ev) begin
      armed_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // waveforms and interrupt requests
  logic pwm_active_q, sq_q, period_irq_q, duty_irq_q;

  always_ff @(posedge clk) begin
    if (srst || !running) begin
      pwm_active_q <= 1'b0;
    end else if (zero_ev) begin
      pwm_active_q <= (dbuf_nx != CNT_ZERO);
    end else if (duty_hit) begin
      pwm_active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sq_q <= 1'b0;
    end else if (!running) begin
      sq_q <= sq_level;
    end else if (clear_ev) begin
      sq_q <= ~sq_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      period_irq_q <= 1'b0;
      duty_irq_q <= 1'b0;
    end else begin
      period_irq_q <= clear_ev;
      duty_irq_q <= running && duty_hit;
    end
  end

  // level bit inverts the active sense; a stopped pin rests at its level, the enable bit drives only the oe output
  assign pwm_out_pin = pwm_active_q ^ pwm_out_level;
  assign pwm_out_oe = pwm_out_enable;
  assign square_wave_out_pin = sq_q;
  assign square_wave_out_oe = sq_enable;
  assign period_match_irq = period_irq_q;
  assign duty_match_irq = duty_irq_q;

  ////////////////////////////////////////////////////////////////////////
  // bus read side
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] rd_idx;

  assign rd_idx = bus_req.araddr[5:2];

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (bus_req.arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      if (!mapped(bus_req.araddr)) begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end else if (rd_idx == IDX_COUNT) begin
        rdata_q <= {16'h0000, cnt_q};
        rresp_q <= RESP_OKAY;
      end else begin
        rdata_q <= {16'h0000, regs_q[rd_idx]};
        rresp_q <= RESP_OKAY;
      end
    end else if (bus_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    bus_rsp.awready = !aw_full_q && !bvalid_q;
    bus_rsp.wready = !w_full_q && !bvalid_q;
    bus_rsp.bresp = bresp_q;
    bus_rsp.bvalid = bvalid_q;
    bus_rsp.arready = !rvalid_q;
    bus_rsp.rdata = rdata_q;
    bus_rsp.rresp = rresp_q;
    bus_rsp.rvalid = rvalid_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_start_wrap;
    !running ##1 running |-> cnt_q == CNT_IDLE;
  endproperty
  a_start_wrap: assert property (p_start_wrap) else $error("counter not idle at start");

  property p_period_clear;
    running && clear_ev |=> cnt_q == CNT_ZERO && period_match_irq;
  endproperty
  a_period_clear: assert property (p_period_clear) else $error("no clear or irq");

  property p_duty_irq;
    duty_match_irq |-> cnt_q == dbuf_q && !pwm_active_q;
  endproperty
  a_duty_irq: assert property (p_duty_irq) else $error("duty irq misaligned");

  property p_pwm_on_clear;
    running && zero_ev && dbuf_nx != CNT_ZERO |=> pwm_active_q;
  endproperty
  a_pwm_on_clear: assert property (p_pwm_on_clear) else $error("pwm not set at clear");

  property p_shadow_hold;
    running ##0 running && !clear_ev |=> $stable(pbuf_q) && $stable(dbuf_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed early");

  property p_stop;
    !running |=> cnt_q == CNT_IDLE && !pwm_active_q;
  endproperty
  a_stop: assert property (p_stop) else $error("counter runs while stopped");

  property p_square_toggle;
    running && clear_ev |=> square_wave_out_pin != $past(square_wave_out_pin);
  endproperty
  a_square_toggle: assert property (p_square_toggle) else $error("square missed toggle");

  property p_zero_duty;
    running && dbuf_q == CNT_ZERO |-> !pwm_active_q;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty went active");

  property p_arm_by_duty;
    $rose(armed_q) |-> $past(duty_wr);
  endproperty
  a_arm_by_duty: assert property (p_arm_by_duty) else $error("arm without duty write");

  property p_full_duty;
    running && dbuf_q > pbuf_q && cnt_q <= pbuf_q |-> pwm_active_q;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty went inactive");

  c_period: cover property (period_match_irq ##[1:300] period_match_irq);
  c_duty: cover property (duty_match_irq ##[1:300] period_match_irq);
  c_transfer: cover property (armed_q && clear_ev);
  c_count_read: cover property (bus_req.arvalid && rd_idx == IDX_COUNT && !rvalid_q);

endmodule // timer_unit

// ==== test_timer_unit.sv ====
// self-checking testbench of the timer unit in pwm output mode
`timescale 1ns/100ps
module test_timer_unit;
  import pwm_timer_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  axil_req_s bus_req = '0;
  axil_rsp_s bus_rsp;
  logic pwm_out_pin, pwm_out_oe, square_wave_out_pin, square_wave_out_oe;
  logic period_match_irq, duty_match_irq;
  int fail_count = 0;
  int total_checks = 0;
  integer seed = 31;
  // bench model: compare registers, shadow buffers and a pending transfer
  int per_reg = 0, duty_reg = 0, per_buf = 0, duty_buf = 0, cks = 0, ioc = 0;
  bit armed = 0, running = 0;
  int len, act, dirq, tog, bad;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [15:0] vals [7];
  logic [3:0] idxs [7] = '{IDX_CTL2, IDX_IOC1, IDX_IOC2, IDX_CTL3, IDX_OPT0, IDX_OPT1, IDX_TCW};

  always #10 clk = ~clk;

  timer_unit u_dut (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe),
    .square_wave_out_pin(square_wave_out_pin), .square_wave_out_oe(square_wave_out_oe),
    .period_match_irq(period_match_irq), .duty_match_irq(duty_match_irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_wave(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks hold each channel until its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    @(posedge clk);
    bus_req.awaddr <= a;
    bus_req.awvalid <= 1'b1;
    bus_req.wdata <= {16'h0000, d};
    bus_req.wstrb <= s;
    bus_req.wvalid <= 1'b1;
    bus_req.bready <= 1'b1;
    n = 0;
    r = 2'h3;
    while (n < 200) begin
      @(posedge clk);
      n++;
      if (bus_req.awvalid && bus_rsp.awready === 1'b1) bus_req.awvalid <= 1'b0;
      if (bus_req.wvalid && bus_rsp.wready === 1'b1) bus_req.wvalid <= 1'b0;
      if (bus_rsp.bvalid === 1'b1) begin
        r = bus_rsp.bresp;
        bus_req.bready <= 1'b0;
        n = 999;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    bus_req.araddr <= a;
    bus_req.arvalid <= 1'b1;
    bus_req.rready <= 1'b1;
    n = 0;
    d = '1;
    r = 2'h3;
    while (n < 200) begin
      @(posedge clk);
      n++;
      if (bus_req.arvalid && bus_rsp.arready === 1'b1) bus_req.arvalid <= 1'b0;
      if (bus_rsp.rvalid === 1'b1) begin
        d = bus_rsp.rdata;
        r = bus_rsp.rresp;
        bus_req.rready <= 1'b0;
        n = 999;
      end
    end
  endtask

  task automatic reg_wr(input logic [3:0] i, input logic [15:0] d);
    axi_wr({2'b00, i, 2'b00}, d, 4'hF, rs);
    chk_rd({30'h0, rs}, {30'h0, RESP_OKAY}, "write response");
    if (i == IDX_PERIOD) per_reg = d;
    if (i == IDX_DUTY) begin
      duty_reg = d;
      armed = 1;
    end
    if (i == IDX_IOC0) ioc = d & MASK_IOC0;
    if (i == IDX_CTL0) begin
      running = d[CTL0_CE];
      cks = d[2:0];
    end
    if (!running) begin
      per_buf = per_reg;
      duty_buf = duty_reg;
      armed = 0;
    end
  endtask

  task automatic reg_rd(input logic [3:0] i, input logic [31:0] exp);
    axi_rd({2'b00, i, 2'b00}, rd, rs);
    chk_rd(rd, exp, "register read");
  endtask

  task automatic idle_chk();
    chk_rd({30'h0, square_wave_out_pin, pwm_out_pin}, {30'h0, ioc[1], ioc[3]}, "idle");
    chk_rd({30'h0, square_wave_out_oe, pwm_out_oe}, {30'h0, ioc[0], ioc[2]}, "oe");
    reg_rd(IDX_COUNT, 32'h0000FFFF);
  endtask

  // no request may leave the block while it is not counting in pwm mode
  task automatic quiet_chk(input string what);
    int q;
    q = 0;
    repeat (60) begin
      @(posedge clk);
      q += (period_match_irq !== 1'b0 || duty_match_irq !== 1'b0);
    end
    chk_wave(q, 0, what);
    idle_chk();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one window runs from a period clear to the next one
  task automatic measure(input bit fresh);
    int n;
    logic a, pa, ps;
    n = 0;
    if (fresh) @(posedge clk);
    while (period_match_irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (armed) begin
      per_buf = per_reg;
      duty_buf = duty_reg;
      armed = 0;
    end
    len = 0;
    act = 0;
    dirq = 0;
    tog = 0;
    bad = 0;
    pa = pwm_out_pin ^ ioc[3];
    ps = square_wave_out_pin;
    do begin
      @(posedge clk);
      len++;
      a = pwm_out_pin ^ ioc[3];
      act += (a === 1'b1);
      dirq += (duty_match_irq === 1'b1);
      bad += (duty_match_irq === 1'b1 && duty_buf != 0 && !(pa === 1'b1 && a === 1'b0));
      bad += $isunknown({a, duty_match_irq, period_match_irq, square_wave_out_pin});
      tog += (square_wave_out_pin !== ps);
      ps = square_wave_out_pin;
      pa = a;
    end while (period_match_irq !== 1'b1 && len < 5000);
    chk_wave(len, (per_buf + 1) << cks, "period length");
    chk_wave(act, ((duty_buf > per_buf) ? per_buf + 1 : duty_buf) << cks, "active");
    chk_wave(dirq, (duty_buf <= per_buf) ? 1 : 0, "duty irq count");
    chk_wave(bad, 0, "duty irq off pwm edge");
    chk_wave(tog, 1, "square toggles");
  endtask

  task automatic run_case(input int p, input int d, input int c, input bit lv);
    reg_wr(IDX_CTL0, 16'h0000);
    reg_wr(IDX_IOC0, {12'h000, lv, 1'b1, lv, lv});
    reg_wr(IDX_PERIOD, p[15:0]);
    reg_wr(IDX_DUTY, d[15:0]);
    reg_wr(IDX_CTL1, {12'h000, MODE_PWM});
    idle_chk();
    reg_wr(IDX_CTL0, 16'h0080 | c[15:0]);
    measure(1);
    measure(0);
    axi_rd({2'b00, IDX_COUNT, 2'b00}, rd, rs);
    chk_rd({31'h0, rd <= per_buf}, 32'h1, "live count");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < REG_COUNT; i++) begin
      reg_rd(i[3:0], (i == IDX_COUNT) ? 32'h0000FFFF : 32'h0);
    end
    axi_wr(8'h34, 16'h1234, 4'hF, rs);
    chk_rd({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(8'h06, rd, rs);
    chk_rd({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "misaligned read");
    reg_wr(IDX_COUNT, 16'h1234);
    reg_rd(IDX_COUNT, 32'h0000FFFF);
    reg_wr(IDX_IOC0, 16'hFFFF);
    reg_rd(IDX_IOC0, 32'h0000000F);
    axi_wr({2'b00, IDX_PERIOD, 2'b00}, 16'hABCD, 4'h2, rs);
    reg_rd(IDX_PERIOD, 32'h0000AB00);
    $display("test 1 done");
    run_case(5, 2, 0, 0);
    reg_wr(IDX_DUTY, 16'h0004);
    measure(1);
    reg_wr(IDX_PERIOD, 16'h0008);
    measure(1);
    reg_wr(IDX_DUTY, 16'h0004);
    measure(1);
    reg_wr(IDX_PERIOD, 16'h0003);
    reg_wr(IDX_DUTY, 16'h0001);
    measure(1);
    $display("test 2 done");
    for (int i = 0; i < 7; i++) begin
      vals[i] = 16'($random(seed)) & 16'h00FF;
      reg_wr(idxs[i], vals[i]);
    end
    measure(1);
    for (int i = 0; i < 7; i++) reg_rd(idxs[i], {16'h0, vals[i]});
    $display("test 3 done");
    run_case(6, 0, 1, 1);
    run_case(6, 7, 0, 1);
    for (int k = 0; k < 3; k++) begin
      len = 1 + ($unsigned($random(seed)) % 12);
      act = $unsigned($random(seed)) % (len + 2);
      run_case(len, act, $unsigned($random(seed)) % 3, k[0]);
    end
    $display("test 4 done");
    reg_wr(IDX_CTL1, 16'h0005);
    quiet_chk("irq outside pwm mode");
    reg_wr(IDX_CTL1, {12'h000, MODE_PWM});
    reg_wr(IDX_CTL0, 16'h0000);
    quiet_chk("irq while stopped");
    $display("test 5 done");
    give_verdict();
  end
endmodule // test_timer_unit
